// ---- design/cpu_status_config_regs.v ----
// Purpose: core status word and configuration word with their side effects
// Assumes: core event strobes are one-cycle pulses on aclk
// Notes:   registers reached over an AXI4-Lite slave, 16 bits in low half
//
// How it works
// - carry set on add/sub carry or borrow
// - trace raises step trap, not in handler
// - pending copies trace at start, trap at end
// - low flag from unsigned compare
// - negative flag from signed compare
// - zero flag when compared operands equal
// - add/sub overflow goes to general flag
// - user bit selects user stack pointer
// - exception taken clears user bit
// - user-mode user stack access raises illegal trap
// - maskable irq needs local and global enables
// - unmask sets, mask clears local enable
// - interrupt clears global enable, return sets it
// - branches decide from five status flags
// - reset clears status, local enable set
// - warm reset saves old status word
// - bits 4, 8 zero; 12-15 reserved
// - flags change only on affecting events
// - reset clears whole configuration word
// - entry width bit sets dispatch entry size
// - narrow bit pairs 16-bit registers
// - pairs put low half in lower register
//
// Implementation choices: the placing of the registers and the AXI4-Lite slave port.
`include "cpu_status_map.vh"
module cpu_status_config_regs #(
  parameter W  = 16,
  parameter VW = 8
) (
  // clock and reset
  input  wire          aclk,
  input  wire          aresetn,
  input  wire          warm_reset,
  // register bus write address / data / response
  input  wire [31:0]   awaddr,
  input  wire [2:0]    awprot,
  input  wire          awvalid,
  output reg           awready_r,
  input  wire [31:0]   wdata,
  input  wire [3:0]    wstrb,
  input  wire          wvalid,
  output reg           wready_r,
  output reg  [1:0]    bresp_r,
  output reg           bvalid_r,
  input  wire          bready,
  // register bus read
  input  wire [31:0]   araddr,
  input  wire [2:0]    arprot,
  input  wire          arvalid,
  output reg           arready_r,
  output reg  [31:0]   rdata_r,
  output reg  [1:0]    rresp_r,
  output reg           rvalid_r,
  input  wire          rready,
  // arithmetic and comparison events
  input  wire          alu_done,
  input  wire          alu_sub,
  input  wire [W-1:0]  alu_a,
  input  wire [W-1:0]  alu_b,
  input  wire          cmp_done,
  input  wire [W-1:0]  cmp_first,
  input  wire [W-1:0]  cmp_second,
  // instruction sequencing
  input  wire          instr_start,
  input  wire          instr_end,
  input  wire          exc_take,
  input  wire          irq_take,
  input  wire          exc_return,
  input  wire          irq_return,
  input  wire          irq_unmask_instr,
  input  wire          irq_mask_instr,
  input  wire          jump_to_user_instr,
  input  wire          usp_access,
  // interrupt requests
  input  wire          irq_request,
  input  wire          nmi_request,
  // branch decision
  input  wire          br_valid,
  input  wire [3:0]    br_cond,
  // register pair and dispatch inputs
  input  wire [W-1:0]  pair_lo_word,
  input  wire [W-1:0]  pair_hi_word,
  input  wire [2*W-1:0] wide_reg_word,
  input  wire          pair_uses_wide,
  input  wire [VW-1:0] vec_index,
  // status outputs
  output reg  [W-1:0]  status_word_r,
  output reg  [W-1:0]  config_word_r,
  output reg  [W-1:0]  saved_r2_r,
  output reg           saved_r2_valid_r,
  output reg           user_stack_sel_r,
  output reg           step_trap_r,
  output reg           illegal_op_trap_r,
  output reg           irq_accept_r,
  output reg           nmi_accept_r,
  output reg           branch_take_r,
  output reg  [2*W-1:0] pair_value_r,
  output reg  [VW+1:0] dispatch_offset_r
);
  // write channel holding registers and the handler-active flag
  reg [3:0]    awaddr_r;
  reg          aw_held_r;
  reg [W-1:0]  wdata_r;
  reg [1:0]    wstrb_r;
  reg          w_held_r;
  reg          handler_active_r;

  wire         wr_fire;
  wire [W-1:0] wr_lanes;
  wire         f_carry;
  wire         f_ovf;
  wire         f_low;
  wire         f_neg;
  wire         f_zero;
  wire         br_take;
  wire         ar_fire;
  reg  [W-1:0] sw_nxt;
  reg  [W-1:0] cf_nxt;
  reg  [31:0]  rd_mux;
  reg  [1:0]   rd_resp;

  flag_calc #(
    .W (W)
  ) u_flags (
    .alu_a      (alu_a),
    .alu_b      (alu_b),
    .alu_sub    (alu_sub),
    .cmp_first  (cmp_first),
    .cmp_second (cmp_second),
    .carry      (f_carry),
    .overflow   (f_ovf),
    .low        (f_low),
    .neg        (f_neg),
    .zero       (f_zero)
  );

  cond_eval u_cond (
    .cond    (br_cond),
    .f_zero  (status_word_r[`SW_ZERO]),
    .f_carry (status_word_r[`SW_CARRY]),
    .f_low   (status_word_r[`SW_LOW]),
    .f_neg   (status_word_r[`SW_NEG]),
    .f_flag  (status_word_r[`SW_FLAG]),
    .take    (br_take)
  );

  // write takes effect once both address and data are held
  assign wr_fire  = aw_held_r & w_held_r & ~bvalid_r;
  assign wr_lanes = {{(W/2){wstrb_r[1]}}, {(W/2){wstrb_r[0]}}};
  assign ar_fire  = arvalid & arready_r;

  // status word next value: software write first, hardware events after,
  // so an event in the cycle of a write is never lost
  always @* begin
    sw_nxt = status_word_r;
    if (wr_fire && awaddr_r == `OFF_STATUS) begin
      sw_nxt = (status_word_r & ~(wr_lanes & `SW_WMASK))
             | (wdata_r & wr_lanes & `SW_WMASK);
    end
    if (alu_done) begin
      sw_nxt[`SW_CARRY] = f_carry;
      sw_nxt[`SW_FLAG]  = f_ovf;
    end
    if (cmp_done) begin
      sw_nxt[`SW_LOW]  = f_low;
      sw_nxt[`SW_NEG]  = f_neg;
      sw_nxt[`SW_ZERO] = f_zero;
    end
    if (instr_start) begin
      sw_nxt[`SW_PEND] = status_word_r[`SW_TRACE] & ~handler_active_r;
    end else if (instr_end && status_word_r[`SW_PEND]) begin
      sw_nxt[`SW_PEND] = 1'b0;
    end
    if (irq_unmask_instr) begin
      sw_nxt[`SW_LOCAL_IE] = 1'b1;
    end else if (irq_mask_instr) begin
      sw_nxt[`SW_LOCAL_IE] = 1'b0;
    end
    if (jump_to_user_instr) begin
      sw_nxt[`SW_USER] = 1'b1;
    end
    if (irq_return) begin
      sw_nxt[`SW_GLOBAL_IE] = 1'b1;
    end
    if (irq_take) begin
      sw_nxt[`SW_GLOBAL_IE] = 1'b0;
    end
    if (exc_take || irq_take) begin
      sw_nxt[`SW_USER] = 1'b0;
    end
    sw_nxt = sw_nxt & `SW_WMASK;
  end

  // configuration word next value
  always @* begin
    cf_nxt = config_word_r;
    if (wr_fire && awaddr_r == `OFF_CONFIG) begin
      cf_nxt = (config_word_r & ~(wr_lanes & `CF_WMASK))
             | (wdata_r & wr_lanes & `CF_WMASK);
    end
  end

  // read mux, unmapped addresses answer with an error
  always @* begin
    rd_mux  = 32'h0000_0000;
    rd_resp = `RESP_OKAY;
    case (araddr[3:0])
      `OFF_STATUS: rd_mux = {16'h0000, status_word_r};
      `OFF_CONFIG: rd_mux = {16'h0000, config_word_r};
      `OFF_SAVED:  rd_mux = {15'h0, saved_r2_valid_r, saved_r2_r};
      `OFF_CORE:   rd_mux = {30'h0, handler_active_r, user_stack_sel_r};
      default:     rd_resp = `RESP_SLVERR;
    endcase
    if (araddr[31:4] != 28'h000_0000) begin
      rd_resp = `RESP_SLVERR;
    end
  end

  // register bus write path
  always @(posedge aclk) begin
    if (!aresetn) begin
      awaddr_r  <= 4'h0;
      aw_held_r <= 1'b0;
      awready_r <= 1'b1;
      wdata_r   <= 16'h0000;
      wstrb_r   <= 2'h0;
      w_held_r  <= 1'b0;
      wready_r  <= 1'b1;
      bvalid_r  <= 1'b0;
      bresp_r   <= `RESP_OKAY;
    end else begin
      if (awvalid && awready_r) begin
        // upper address bits fold into an out-of-range code
        awaddr_r  <= (awaddr[31:4] != 28'h000_0000) ? 4'h1 : awaddr[3:0];
        aw_held_r <= 1'b1;
        awready_r <= 1'b0;
      end
      if (wvalid && wready_r) begin
        wdata_r  <= wdata[15:0];
        wstrb_r  <= wstrb[1:0];
        w_held_r <= 1'b1;
        wready_r <= 1'b0;
      end
      if (wr_fire) begin
        aw_held_r <= 1'b0;
        w_held_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= (awaddr_r == `OFF_STATUS || awaddr_r == `OFF_CONFIG) ?
                     `RESP_OKAY : `RESP_SLVERR;
      end
      if (bvalid_r && bready) begin
        bvalid_r  <= 1'b0;
        awready_r <= 1'b1;
        wready_r  <= 1'b1;
      end
    end
  end

  // register bus read path
  always @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0000_0000;
      rresp_r   <= `RESP_OKAY;
    end else begin
      if (ar_fire) begin
        arready_r <= 1'b0;
        rvalid_r  <= 1'b1;
        rdata_r   <= rd_mux;
        rresp_r   <= rd_resp;
      end else if (rvalid_r && rready) begin
        rvalid_r  <= 1'b0;
        arready_r <= 1'b1;
      end
    end
  end

  // status and configuration words, warm reset restarts both
  always @(posedge aclk) begin
    if (!aresetn) begin
      status_word_r    <= `SW_RESET;
      config_word_r    <= `CF_RESET;
      saved_r2_r       <= 16'h0000;
      saved_r2_valid_r <= 1'b0;
      handler_active_r <= 1'b0;
    end else if (warm_reset) begin
      saved_r2_r       <= status_word_r;
      saved_r2_valid_r <= 1'b1;
      status_word_r    <= `SW_RESET;
      config_word_r    <= `CF_RESET;
      handler_active_r <= 1'b0;
    end else begin
      status_word_r <= sw_nxt;
      config_word_r <= cf_nxt;
      // nested handlers are not counted: one return ends suppression
      if (exc_take || irq_take) begin
        handler_active_r <= 1'b1;
      end else if (exc_return || irq_return) begin
        handler_active_r <= 1'b0;
      end
    end
  end

  // core-facing strobes and derived values
  always @(posedge aclk) begin
    if (!aresetn || warm_reset) begin
      user_stack_sel_r  <= 1'b0;
      step_trap_r       <= 1'b0;
      illegal_op_trap_r <= 1'b0;
      irq_accept_r      <= 1'b0;
      nmi_accept_r      <= 1'b0;
      branch_take_r     <= 1'b0;
      pair_value_r      <= 32'h0000_0000;
      dispatch_offset_r <= {(VW+2){1'b0}};
    end else begin
      user_stack_sel_r  <= sw_nxt[`SW_USER];
      step_trap_r       <= instr_end & ~instr_start & status_word_r[`SW_PEND]
                           & ~handler_active_r;
      illegal_op_trap_r <= usp_access & status_word_r[`SW_USER];
      irq_accept_r      <= irq_request & status_word_r[`SW_LOCAL_IE]
                           & status_word_r[`SW_GLOBAL_IE];
      nmi_accept_r      <= nmi_request;
      branch_take_r     <= br_valid & br_take;
      // wide registers are single operands only outside the narrow mode
      if (pair_uses_wide && !config_word_r[`CF_NARROW]) begin
        pair_value_r <= wide_reg_word;
      end else begin
        pair_value_r <= {pair_hi_word, pair_lo_word};
      end
      // base address stays outside, only the entry offset scales
      if (config_word_r[`CF_ENTRY_WIDTH]) begin
        dispatch_offset_r <= {vec_index, 2'b00};
      end else begin
        dispatch_offset_r <= {1'b0, vec_index, 1'b0};
      end
    end
  end
endmodule // cpu_status_config_regs

// ---- design/cpu_status_map.vh ----
// Purpose: constants for the core status word and configuration word block
// Assumes: 16-bit words carried in the low half of a 32-bit register bus word
// Notes:   bus offsets are byte addresses, one aligned word per register
`ifndef CPU_STATUS_MAP_VH
`define CPU_STATUS_MAP_VH

// register bus byte offsets
`define OFF_STATUS       4'h0
`define OFF_CONFIG       4'h4
`define OFF_SAVED        4'h8
`define OFF_CORE         4'hc

// status word bit positions
`define SW_CARRY         0
`define SW_TRACE         1
`define SW_LOW           2
`define SW_USER          3
`define SW_FLAG          5
`define SW_ZERO          6
`define SW_NEG           7
`define SW_LOCAL_IE      9
`define SW_PEND          10
`define SW_GLOBAL_IE     11

// configuration word bit positions
`define CF_ENTRY_WIDTH   8
`define CF_NARROW        9

// reset values and writable masks
`define SW_RESET         16'h0200
`define CF_RESET         16'h0000
`define SW_WMASK         16'h0eef
`define CF_WMASK         16'h0300

// bus responses
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

// branch condition codes
`define CC_EQ            4'h0
`define CC_NE            4'h1
`define CC_CS            4'h2
`define CC_CC            4'h3
`define CC_HI            4'h4
`define CC_LS            4'h5
`define CC_GT            4'h6
`define CC_LE            4'h7
`define CC_FS            4'h8
`define CC_FC            4'h9
`define CC_LO            4'ha
`define CC_HS            4'hb
`define CC_LT            4'hc
`define CC_GE            4'hd
`define CC_UC            4'he

`endif

// ---- design/flag_calc.v ----
// Purpose: arithmetic and comparison flag values for one operation
// Assumes: operands arrive from logic on the core clock
// Notes:   purely combinational, the caller decides when flags are kept
module flag_calc #(
  parameter W = 16
) (
  // add / subtract operands
  input  wire [W-1:0] alu_a,
  input  wire [W-1:0] alu_b,
  input  wire         alu_sub,
  // comparison operands
  input  wire [W-1:0] cmp_first,
  input  wire [W-1:0] cmp_second,
  // results
  output wire         carry,
  output wire         overflow,
  output wire         low,
  output wire         neg,
  output wire         zero
);
  wire [W:0]   sum;
  wire [W-1:0] b_eff;

  assign b_eff    = alu_sub ? ~alu_b : alu_b;
  assign sum      = {1'b0, alu_a} + {1'b0, b_eff} + {{W{1'b0}}, alu_sub};
  // borrow is the inverse of the two's complement carry out
  assign carry    = alu_sub ? ~sum[W] : sum[W];
  assign overflow = (alu_a[W-1] == b_eff[W-1]) && (sum[W-1] != alu_a[W-1]);
  assign low      = cmp_second < cmp_first;
  assign neg      = $signed(cmp_second) < $signed(cmp_first);
  assign zero     = cmp_second == cmp_first;
endmodule // flag_calc

// ---- design/cond_eval.v ----
// Purpose: decides a conditional branch from the status flags
// Assumes: condition codes as named in the map header
// Notes:   code 4'hf and unknown codes never branch
`include "cpu_status_map.vh"
module cond_eval (
  // condition and flags
  input  wire [3:0] cond,
  input  wire       f_zero,
  input  wire       f_carry,
  input  wire       f_low,
  input  wire       f_neg,
  input  wire       f_flag,
  // decision
  output reg        take
);
  always @* begin
    case (cond)
      `CC_EQ: take = f_zero;
      `CC_NE: take = ~f_zero;
      `CC_CS: take = f_carry;
      `CC_CC: take = ~f_carry;
      `CC_HI: take = f_low;
      `CC_LS: take = ~f_low;
      `CC_GT: take = f_neg;
      `CC_LE: take = ~f_neg;
      `CC_FS: take = f_flag;
      `CC_FC: take = ~f_flag;
      `CC_LO: take = ~f_low & ~f_zero;
      `CC_HS: take = f_low | f_zero;
      `CC_LT: take = ~f_neg & ~f_zero;
      `CC_GE: take = f_neg | f_zero;
      `CC_UC: take = 1'b1;
      default: take = 1'b0;
    endcase
  end
endmodule // cond_eval

// ---- test/cpu_status_config_regs_asserts.sv ----
// Purpose: concurrent checks on the status and configuration word block
// Assumes: sees only top-level ports, attached by bind from the bench
// Notes:   warm reset overrides core events, so it is excluded there
module cpu_status_config_regs_asserts (
  // clock, resets and core events
  input wire logic        aclk, aresetn, warm_reset, alu_done, alu_sub, cmp_done,
  input wire logic        instr_start, instr_end, exc_take, irq_take, usp_access,
  input wire logic        irq_request,
  input wire logic [15:0] alu_a, alu_b, cmp_first, cmp_second,
  // observed state
  input wire logic [15:0] status_word_r, saved_r2_r,
  input wire logic        saved_r2_valid_r, step_trap_r, illegal_op_trap_r, irq_accept_r
);
  timeunit 1ns;
  timeprecision 1ns;
  wire [16:0] sum = alu_a + alu_b;
  wire [15:0] res = alu_sub ? alu_a - alu_b : sum[15:0];
  wire        cy  = alu_sub ? (alu_a < alu_b) : sum[16];
  // overflow: sign of result differs from a, operands agree (add) or differ (sub)
  wire        ov  = (alu_a[15] ^ res[15]) & (alu_a[15] ^ alu_b[15] ^ !alu_sub);
  wire [15:0] sw  = status_word_r;

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_carry; alu_done && !warm_reset |=> sw[0] == $past(cy); endproperty
  a_carry: assert property (p_carry) else $error("carry flag wrong");
  property p_ovf; alu_done && !warm_reset |=> sw[5] == $past(ov); endproperty
  a_ovf: assert property (p_ovf) else $error("overflow flag wrong");
  property p_low; cmp_done && !warm_reset |=> sw[2] == $past(cmp_second < cmp_first);
  endproperty
  a_low: assert property (p_low) else $error("low flag wrong");
  property p_neg;
    cmp_done && !warm_reset |=> sw[7] == $past($signed(cmp_second) < $signed(cmp_first));
  endproperty
  a_neg: assert property (p_neg) else $error("negative flag wrong");
  property p_zero; cmp_done && !warm_reset |=> sw[6] == $past(cmp_second == cmp_first);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");
  property p_step; step_trap_r |-> $past(instr_end && !instr_start && sw[10]); endproperty
  a_step: assert property (p_step) else $error("step trap without pending");
  property p_irq; !warm_reset |=> irq_accept_r == $past(irq_request && sw[9] && sw[11]);
  endproperty
  a_irq: assert property (p_irq) else $error("maskable accept wrong");
  property p_gie; irq_take && !warm_reset |=> !sw[11] && !sw[3]; endproperty
  a_gie: assert property (p_gie) else $error("global enable kept on irq");
  property p_exc; exc_take && !warm_reset |=> !sw[3]; endproperty
  a_exc: assert property (p_exc) else $error("user mode kept on exception");
  property p_illegal; !warm_reset |=> illegal_op_trap_r == $past(usp_access && sw[3]);
  endproperty
  a_illegal: assert property (p_illegal) else $error("illegal trap wrong");
  property p_reset; $rose(aresetn) |-> sw == 16'h0200; endproperty
  a_reset: assert property (p_reset) else $error("status reset value wrong");
  property p_fixed; (sw & 16'hf110) == 16'h0000; endproperty
  a_fixed: assert property (p_fixed) else $error("fixed bits not zero");
  property p_warm;
    warm_reset |=> saved_r2_r == $past(sw) ##0 saved_r2_valid_r ##0 sw == 16'h0200;
  endproperty
  a_warm: assert property (p_warm) else $error("warm reset save wrong");

  c_alu: cover property (alu_done);
  c_trap: cover property (step_trap_r);
  c_warm: cover property (warm_reset);
endmodule // cpu_status_config_regs_asserts

// ---- test/cpu_status_config_regs_test.sv ----
// Purpose: directed bench for the status and configuration word block
// Assumes: core events are driven as one-cycle pulses through ev
// Notes:   each scenario task judges its own results
`include "cpu_status_map.vh"
module cpu_status_config_regs_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, alu_sub;
  logic irq_request, nmi_request, pair_uses_wide;
  logic [31:0] awaddr, wdata, araddr, wide_reg_word, rdata_r, pair_value_r;
  logic [3:0] wstrb, br_cond;
  logic [15:0] alu_a, alu_b, cmp_first, cmp_second, pair_lo_word, pair_hi_word;
  logic [7:0] vec_index;
  logic [13:0] ev;
  logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r, saved_r2_valid_r;
  logic user_stack_sel_r, step_trap_r, illegal_op_trap_r, irq_accept_r;
  logic nmi_accept_r, branch_take_r;
  logic [1:0] bresp_r, rresp_r;
  logic [15:0] status_word_r, config_word_r, saved_r2_r;
  logic [9:0] dispatch_offset_r;
  int n_mismatch = 0;
  int n_compared = 0;

  cpu_status_config_regs dut (
    .awprot(3'h0), .arprot(3'h0),
    .instr_start(ev[0]), .instr_end(ev[1]), .exc_take(ev[2]), .irq_take(ev[3]),
    .exc_return(ev[4]), .irq_return(ev[5]), .irq_unmask_instr(ev[6]),
    .irq_mask_instr(ev[7]), .jump_to_user_instr(ev[8]), .usp_access(ev[9]),
    .alu_done(ev[10]), .cmp_done(ev[11]), .warm_reset(ev[12]), .br_valid(ev[13]), .*);

  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  task chk(input string n, input logic [31:0] e, g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  task end_of_test;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task ev1(input int k);
    ev[k] <= 1'b1;
    @(posedge aclk);
    ev[k] <= 1'b0;
    @(posedge aclk);
  endtask

  task wr(input [31:0] a, input [15:0] d, output [1:0] r);
    bit ta, tw;
    ta = 1;
    tw = 1;
    awaddr <= a;
    wdata <= {16'h0, d};
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (ta | tw) begin
      @(posedge aclk);
      if (ta && awready_r) begin
        awvalid <= 0;
        ta = 0;
      end
      if (tw && wready_r) begin
        wvalid <= 0;
        tw = 0;
      end
    end
    do @(posedge aclk); while (!bvalid_r);
    r = bresp_r;
    bready <= 0;
    // one idle edge so a following call never reassigns bready in this step
    @(posedge aclk);
  endtask

  task rd(input [31:0] a, output [31:0] d, output [1:0] r);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do @(posedge aclk); while (!arready_r);
    arvalid <= 0;
    do @(posedge aclk); while (!rvalid_r);
    d = rdata_r;
    r = rresp_r;
    rready <= 0;
    @(posedge aclk);
  endtask

  task t_regs;
    logic [31:0] d;
    logic [1:0] r;
    rd(`OFF_STATUS, d, r);
    chk("status reset", `SW_RESET, d);
    rd(`OFF_CONFIG, d, r);
    chk("config reset", `CF_RESET, d);
    // ones into constant-zero bits 4 and 8, reserved bits left at zero
    wr(`OFF_STATUS, 16'h0fff, r);
    rd(`OFF_STATUS, d, r);
    chk("status fixed bits", 32'h0eef, d);
    wr(`OFF_STATUS, `SW_RESET, r);
    wr(`OFF_SAVED, 16'h0001, r);
    chk("read-only write resp", `RESP_SLVERR, r);
    rd(32'h10, d, r);
    chk("unmapped read resp", `RESP_SLVERR, r);
    $display("register test done");
  endtask

  task al(input [15:0] a, b, input s, c, f);
    logic [15:0] pre;
    pre = status_word_r;
    alu_a <= a;
    alu_b <= b;
    alu_sub <= s;
    ev1(10);
    chk("carry", c, status_word_r[0]);
    chk("overflow", f, status_word_r[5]);
    chk("untouched flags", pre & 16'hffde, status_word_r & 16'hffde);
  endtask

  task cm(input [15:0] fi, se, input [2:0] lnz);
    cmp_first <= fi;
    cmp_second <= se;
    ev1(11);
    chk("compare flags", lnz, {status_word_r[2], status_word_r[7], status_word_r[6]});
  endtask

  task t_flags;
    al(16'hffff, 16'h0001, 0, 1, 0);
    al(16'h0001, 16'h0002, 1, 1, 0);
    al(16'h7fff, 16'h0001, 0, 0, 1);
    al(16'h8000, 16'h0001, 1, 0, 1);
    cm(16'h0002, 16'h0001, 3'b110);
    cm(16'h0001, 16'hffff, 3'b010);
    cm(16'h0005, 16'h0005, 3'b001);
    // flags now c0 f1 l0 n0 z1: bit i of 16'h69a9 is the decision for code i
    for (int i = 0; i < 16; i++) begin
      br_cond <= i[3:0];
      ev1(13);
      chk("branch", (16'h69a9 >> i) & 1, branch_take_r);
    end
    $display("flag test done");
  endtask

  task t_trace;
    logic [1:0] r;
    wr(`OFF_STATUS, 16'h0202, r);
    ev1(0);
    ev1(1);
    chk("step trap", 1, step_trap_r);
    @(posedge aclk);
    chk("step trap once", 0, step_trap_r);
    ev1(2);
    ev1(0);
    ev1(1);
    chk("trap in handler", 0, step_trap_r);
    ev1(4);
    wr(`OFF_STATUS, 16'h0a00, r);
    $display("trace test done");
  endtask

  task t_irq;
    irq_request <= 1;
    repeat (2) @(posedge aclk);
    chk("irq accept", 1, irq_accept_r);
    ev1(3);
    chk("global enable cleared", 0, status_word_r[11]);
    @(posedge aclk);
    chk("irq blocked", 0, irq_accept_r);
    ev1(5);
    chk("global enable restored", 1, status_word_r[11]);
    chk("local enable kept", 1, status_word_r[9]);
    ev1(7);
    chk("local enable cleared", 0, status_word_r[9]);
    @(posedge aclk);
    chk("irq masked", 0, irq_accept_r);
    ev1(6);
    chk("local enable set", 1, status_word_r[9]);
    irq_request <= 0;
    nmi_request <= 1;
    repeat (2) @(posedge aclk);
    chk("nmi accept", 1, nmi_accept_r);
    nmi_request <= 0;
    $display("interrupt test done");
  endtask

  task t_user;
    ev1(8);
    chk("user mode", 1, status_word_r[3]);
    @(posedge aclk);
    chk("user stack", 1, user_stack_sel_r);
    ev1(9);
    chk("illegal trap", 1, illegal_op_trap_r);
    ev1(2);
    chk("handler supervisor", 0, status_word_r[3]);
    ev1(9);
    chk("supervisor access", 0, illegal_op_trap_r);
    ev1(4);
    $display("user mode test done");
  endtask

  task t_pair;
    logic [1:0] r;
    vec_index <= 8'h05;
    pair_lo_word <= 16'h1111;
    pair_hi_word <= 16'h2222;
    wide_reg_word <= 32'h3333_4444;
    pair_uses_wide <= 1;
    wr(`OFF_CONFIG, 16'h0100, r);
    repeat (2) @(posedge aclk);
    chk("long entry offset", 20, dispatch_offset_r);
    chk("wide pair", 32'h3333_4444, pair_value_r);
    wr(`OFF_CONFIG, 16'h0200, r);
    repeat (2) @(posedge aclk);
    chk("short entry offset", 10, dispatch_offset_r);
    chk("short pair", 32'h2222_1111, pair_value_r);
    $display("pair test done");
  endtask

  task t_warm;
    logic [31:0] d;
    logic [1:0] r;
    wr(`OFF_STATUS, 16'h0ae5, r);
    ev1(12);
    chk("saved status", 16'h0ae5, saved_r2_r);
    chk("status after warm", `SW_RESET, status_word_r);
    chk("config after warm", `CF_RESET, config_word_r);
    rd(`OFF_SAVED, d, r);
    chk("saved read", 32'h0001_0ae5, d);
    $display("warm reset test done");
  endtask

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, alu_sub} = '0;
    {irq_request, nmi_request, pair_uses_wide, ev, br_cond, vec_index} = '0;
    {awaddr, wdata, araddr, wide_reg_word, alu_a, alu_b} = '0;
    {cmp_first, cmp_second, pair_lo_word, pair_hi_word} = '0;
    wstrb = 4'h3;
    repeat (12) @(posedge aclk);
    aresetn <= 1;
    t_regs;
    t_flags;
    t_trace;
    t_irq;
    t_user;
    t_pair;
    t_warm;
    end_of_test;
  end

  // the whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge aclk);
    n_mismatch++;
    end_of_test;
  end
endmodule // cpu_status_config_regs_test

bind cpu_status_config_regs cpu_status_config_regs_asserts u_chk (.*);
